// ==== alarm_pkg.sv ====
// Package of constants and types shared by the channel alarm evaluator
package alarm_pkg;
  localparam int N_CHAN = 18;
  localparam int N_SLOT = 5;
  localparam int N_ENTRY = N_CHAN * N_SLOT;
  localparam int N_RELAY = 12;
  localparam int VAL_W = 16;
  localparam int SEC_W = 16;
  localparam int MSG_W = 160;
  // Timing: one second base at a 10 ns clock
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint SECOND_NS = 1000000000;
  localparam int SEC_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
  localparam logic [9:0] RATE_WIN_MAX = 10'h258;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SEL = 8'h04;
  localparam logic [7:0] OFF_CHCFG = 8'h08;
  localparam logic [7:0] OFF_SLOTCFG = 8'h0C;
  localparam logic [7:0] OFF_SETPT = 8'h10;
  localparam logic [7:0] OFF_HYST = 8'h14;
  localparam logic [7:0] OFF_DELAY = 8'h18;
  localparam logic [7:0] OFF_WIN = 8'h1C;
  localparam logic [7:0] OFF_MSG0 = 8'h20;
  localparam logic [7:0] OFF_MSG4 = 8'h30;
  localparam logic [7:0] OFF_STATUS = 8'h40;
  localparam logic [7:0] OFF_SLOTSTAT = 8'h44;
  // Field positions
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_MUTE = 1;
  localparam int CTRL_RECACC = 2;
  localparam int CHCFG_EN = 0;
  localparam int CHCFG_CLASS = 1;
  localparam int SLOT_EN = 4;
  localparam int SLOT_REC = 5;
  localparam int SLOT_APPEND = 6;
  localparam int SLOT_CONTACT = 8;
  localparam int STAT_ALARM = 0;
  localparam int STAT_ERR = 1;
  localparam int STAT_SOUND = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Slot types
  typedef enum logic [2:0] {
    T_NONE = 3'h0, T_HIGH = 3'h1, T_LOW = 3'h2, T_RATE = 3'h3,
    T_ABNORMAL = 3'h4, T_TRUE = 3'h5, T_FALSE = 3'h6
  } slot_type_t;
  localparam logic LOG_ALARM = 1'b0;
  localparam logic LOG_ACK = 1'b1;
endpackage : alarm_pkg

// ==== channel_alarm_evaluator.sv ====
// Channel alarm evaluator: five alarm slots per channel, indicator, log and relay requests
`timescale 1ns/1ns
module channel_alarm_evaluator
  import alarm_pkg::*;
#(
  parameter int SEC_DIV = alarm_pkg::SEC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic sample_tick,
  input wire logic [alarm_pkg::N_CHAN*alarm_pkg::VAL_W-1:0] chan_value,
  input wire logic [alarm_pkg::N_CHAN-1:0] chan_abnormal,
  input wire logic [alarm_pkg::N_CHAN-1:0] chan_contact,
  input wire logic [alarm_pkg::N_RELAY-1:0] relay_enable,
  input wire logic ack_press,
  input wire logic [31:0] time_stamp,
  output logic led_green,
  output logic led_amber,
  output logic led_red,
  output logic sound_on,
  output logic [alarm_pkg::N_RELAY-1:0] relay_req,
  output logic rec_start,
  output logic log_valid,
  output logic log_kind,
  output logic [31:0] log_time,
  output logic [4:0] log_chan,
  output logic [2:0] log_slot,
  output logic log_msg_valid,
  output logic [alarm_pkg::MSG_W-1:0] log_msg
);
  import alarm_pkg::*;

  // Reset release through two flops
  logic rst_q1;
  logic rst_sync_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_sync_n <= rst_q1;
    end
  end

  // Per-slot and per-channel configuration, written only by the register port
  logic [2:0] cfg_type [N_ENTRY];
  logic [VAL_W-1:0] cfg_sp [N_ENTRY];
  logic [VAL_W-1:0] cfg_hyst [N_ENTRY];
  logic [9:0] cfg_delay [N_ENTRY];
  logic [9:0] cfg_win [N_ENTRY];
  logic [2:0] cfg_flags [N_ENTRY];
  logic [3:0] cfg_contact [N_ENTRY];
  logic [MSG_W-1:0] cfg_msg [N_ENTRY];
  logic [N_CHAN-1:0] ch_en;
  logic [N_CHAN-1:0] ch_class;
  // Per-slot runtime state, written only by the scanner
  logic [N_ENTRY-1:0] cond_on;
  logic [N_ENTRY-1:0] reported;
  logic [SEC_W-1:0] cond_since [N_ENTRY];
  logic [SEC_W-1:0] rate_since [N_ENTRY];
  logic [VAL_W-1:0] rate_ref [N_ENTRY];

  logic [2:0] ctrl;
  logic [4:0] sel_chan;
  logic [2:0] sel_slot;
  logic err_flag;
  logic any_alarm;
  logic acked;
  logic ack_pend;

  // Register decode; selector holds the documented 1-based numbers
  wire master_en = ctrl[CTRL_MASTER];
  wire muted = ctrl[CTRL_MUTE];
  wire sel_ok = sel_chan >= 5'h1 && sel_chan <= 5'(N_CHAN) && sel_slot >= 3'h1 && sel_slot <= 3'(N_SLOT);
  wire [4:0] sel_ch0 = sel_chan - 5'h1;
  wire [6:0] sel_idx = 7'(sel_ch0) * 7'(N_SLOT) + 7'(sel_slot - 3'h1);
  wire wr_sel = reg_wr && reg_addr == OFF_SEL;
  wire [4:0] new_chan = reg_wdata[4:0];
  wire [2:0] new_slot = reg_wdata[10:8];
  wire new_sel_ok = new_chan >= 5'h1 && new_chan <= 5'(N_CHAN) && new_slot >= 3'h1 && new_slot <= 3'(N_SLOT);
  wire [2:0] new_type = reg_wdata[2:0];
  wire sel_contact_cls = ch_class[sel_ch0];
  // Legal type sets per channel class
  wire type_ok = sel_contact_cls ? (new_type == T_NONE || new_type == T_ABNORMAL || new_type == T_TRUE ||
                 new_type == T_FALSE) : (new_type <= T_ABNORMAL);
  wire [VAL_W-1:0] cur_sp = cfg_sp[sel_idx];
  wire [VAL_W-1:0] cur_hyst = cfg_hyst[sel_idx];
  wire [VAL_W-1:0] new_val = reg_wdata[VAL_W-1:0];
  wire wr_slot = reg_wr && sel_ok;
  wire wr_type_ok = wr_slot && reg_addr == OFF_SLOTCFG && type_ok;
  wire wr_sp_ok = wr_slot && reg_addr == OFF_SETPT && $signed(cur_hyst) <= $signed(new_val);
  wire wr_hyst_ok = wr_slot && reg_addr == OFF_HYST && $signed(new_val) <= $signed(cur_sp);
  wire wr_win_ok = wr_slot && reg_addr == OFF_WIN && reg_wdata[9:0] <= RATE_WIN_MAX;
  wire wr_msg = wr_slot && reg_addr >= OFF_MSG0 && reg_addr <= OFF_MSG4 && reg_addr[1:0] == 2'h0;
  wire [2:0] msg_word = 3'(reg_addr[4:2]);
  wire slot_reg = reg_addr == OFF_SLOTCFG || reg_addr == OFF_SETPT || reg_addr == OFF_HYST ||
                  reg_addr == OFF_WIN || reg_addr == OFF_DELAY || reg_addr == OFF_CHCFG ||
                  (reg_addr >= OFF_MSG0 && reg_addr <= OFF_MSG4);
  // Any refused write raises the sticky error, except an unaligned message write, which is dropped silently
  wire bad_write = (wr_sel && !new_sel_ok) || (reg_wr && slot_reg && !sel_ok) ||
                   (wr_slot && reg_addr == OFF_SLOTCFG && !type_ok) ||
                   (wr_slot && reg_addr == OFF_SETPT && !wr_sp_ok) ||
                   (wr_slot && reg_addr == OFF_HYST && !wr_hyst_ok) ||
                   (wr_slot && reg_addr == OFF_WIN && !wr_win_ok);
  wire err_clr = reg_wr && reg_addr == OFF_STATUS && reg_wdata[STAT_ERR];

  // Control, selector and error flag; a new error wins over a clear
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl <= CTRL_RESET;
      sel_chan <= 5'h01;
      sel_slot <= 3'h1;
      err_flag <= 1'b0;
      ch_en <= '0;
      ch_class <= '0;
    end else begin
      if (reg_wr && reg_addr == OFF_CTRL) ctrl <= reg_wdata[2:0];
      if (wr_sel && new_sel_ok) begin
        sel_chan <= new_chan;
        sel_slot <= new_slot;
      end
      if (wr_slot && reg_addr == OFF_CHCFG) begin
        ch_en[sel_ch0] <= reg_wdata[CHCFG_EN];
        ch_class[sel_ch0] <= reg_wdata[CHCFG_CLASS];
      end
      err_flag <= bad_write || (err_flag && !err_clr);
    end
  end

  // Setpoint and hysteresis reset to zero, else the first refusal compare sees unknowns and locks out both
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < N_ENTRY; i++) begin
        cfg_sp[i] <= '0;
        cfg_hyst[i] <= '0;
      end
    end else begin
      if (wr_sp_ok) cfg_sp[sel_idx] <= new_val;
      if (wr_hyst_ok) cfg_hyst[sel_idx] <= new_val;
    end
  end

  // Rest of slot configuration; no reset, software programs before enabling
  always_ff @(posedge clk_sys) begin
    if (wr_type_ok) begin
      cfg_type[sel_idx] <= new_type;
      cfg_flags[sel_idx] <= reg_wdata[6:4];
      cfg_contact[sel_idx] <= reg_wdata[11:8];
    end
    if (wr_slot && reg_addr == OFF_DELAY) cfg_delay[sel_idx] <= reg_wdata[9:0];
    if (wr_win_ok) cfg_win[sel_idx] <= reg_wdata[9:0];
    if (wr_msg) cfg_msg[sel_idx][32*msg_word +: 32] <= reg_wdata;
  end

  // Read mux, answered the cycle after the strobe
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      OFF_CTRL: rd_mux = {29'h0000_0000, ctrl};
      OFF_SEL: rd_mux = {21'h00_0000, sel_slot, 3'h0, sel_chan};
      OFF_CHCFG: rd_mux = {30'h0000_0000, ch_class[sel_ch0], ch_en[sel_ch0]};
      OFF_SLOTCFG: rd_mux = {20'h0_0000, cfg_contact[sel_idx], 1'b0, cfg_flags[sel_idx], 1'b0, cfg_type[sel_idx]};
      OFF_SETPT: rd_mux = {16'h0000, cur_sp};
      OFF_HYST: rd_mux = {16'h0000, cur_hyst};
      OFF_DELAY: rd_mux = {22'h00_0000, cfg_delay[sel_idx]};
      OFF_WIN: rd_mux = {22'h00_0000, cfg_win[sel_idx]};
      OFF_STATUS: rd_mux = {29'h0000_0000, sound_on, err_flag, any_alarm};
      OFF_SLOTSTAT: rd_mux = {30'h0000_0000, reported[sel_idx], cond_on[sel_idx]};
      default: rd_mux = (reg_addr >= OFF_MSG0 && reg_addr <= OFF_MSG4) ? cfg_msg[sel_idx][32*msg_word +: 32]
                        : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) reg_rdata <= 32'h0000_0000;
    else reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  // One second enable and running seconds count
  logic [26:0] div_cnt;
  logic [SEC_W-1:0] sec_now;
  wire sec_tick = div_cnt == 27'(SEC_DIV - 1);
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_cnt <= '0;
      sec_now <= '0;
    end else begin
      div_cnt <= sec_tick ? '0 : div_cnt + 27'h1;
      if (sec_tick) sec_now <= sec_now + 16'h1;
    end
  end

  // Scanner: walks all slots one per cycle after each sample tick taken while idle
  typedef enum logic [1:0] {S_IDLE = 2'b01, S_SCAN = 2'b10} scan_state_t;
  scan_state_t scan_state;
  logic [4:0] sc_ch;
  logic [2:0] sc_sl;
  logic [6:0] sc_idx;
  logic [N_RELAY-1:0] relay_acc;
  logic alarm_acc;
  wire scanning = scan_state == S_SCAN;
  wire last_entry = sc_idx == 7'(N_ENTRY - 1);

  // Current slot evaluation
  wire [2:0] e_type = cfg_type[sc_idx];
  wire signed [VAL_W:0] e_val = $signed({chan_value[{sc_ch, 4'h0} + 9'h00F], chan_value[{sc_ch, 4'h0} +: VAL_W]});
  wire signed [VAL_W:0] e_sp = $signed({cfg_sp[sc_idx][VAL_W-1], cfg_sp[sc_idx]});
  wire signed [VAL_W:0] e_hy = $signed({cfg_hyst[sc_idx][VAL_W-1], cfg_hyst[sc_idx]});
  wire signed [VAL_W:0] e_ref = $signed({rate_ref[sc_idx][VAL_W-1], rate_ref[sc_idx]});
  wire e_on = cond_on[sc_idx];
  // Held high condition releases against the lowered threshold, held low against the raised one
  wire signed [VAL_W:0] hi_thr = e_on ? e_sp - e_hy : e_sp;
  wire signed [VAL_W:0] lo_thr = e_on ? e_sp + e_hy : e_sp;
  wire signed [VAL_W+1:0] delta = 18'(e_val) - 18'(e_ref);
  wire rate_hit = e_sp >= 0 ? delta > 18'(e_sp) : -delta > -18'(e_sp);
  wire [SEC_W-1:0] rate_age = sec_now - rate_since[sc_idx];
  wire rate_roll = rate_age >= 16'(cfg_win[sc_idx]);
  wire is_contact = ch_class[sc_ch];
  logic raw_cond;
  always_comb begin
    raw_cond = 1'b0;
    unique case (e_type)
      T_HIGH: raw_cond = !is_contact && e_val > hi_thr;
      T_LOW: raw_cond = !is_contact && e_val < lo_thr;
      T_RATE: raw_cond = !is_contact && rate_hit;
      T_ABNORMAL: raw_cond = chan_abnormal[sc_ch];
      T_TRUE: raw_cond = is_contact && chan_contact[sc_ch];
      T_FALSE: raw_cond = is_contact && !chan_contact[sc_ch];
      default: raw_cond = 1'b0;
    endcase
  end
  wire e_gate = cfg_flags[sc_idx][0] && ch_en[sc_ch] && master_en;
  wire e_cond = raw_cond && e_gate;
  wire delay_done = sec_now - cond_since[sc_idx] >= 16'(cfg_delay[sc_idx]);
  wire e_report = scanning && e_cond && e_on && !reported[sc_idx] && delay_done;
  wire e_active = e_cond && (reported[sc_idx] || e_report);
  wire [3:0] e_contact = cfg_contact[sc_idx];

  // Scanner sequencing; a tick during a scan is ignored
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      scan_state <= S_IDLE;
      sc_ch <= '0;
      sc_sl <= '0;
      sc_idx <= '0;
    end else begin
      unique case (scan_state)
        S_IDLE: if (sample_tick) scan_state <= S_SCAN;
        S_SCAN: begin
          if (last_entry) begin
            scan_state <= S_IDLE;
            sc_ch <= '0;
            sc_sl <= '0;
            sc_idx <= '0;
          end else begin
            sc_idx <= sc_idx + 7'h1;
            sc_sl <= sc_sl == 3'(N_SLOT - 1) ? 3'h0 : sc_sl + 3'h1;
            if (sc_sl == 3'(N_SLOT - 1)) sc_ch <= sc_ch + 5'h1;
          end
        end
      endcase
    end
  end

  // Per-slot state update; losing the condition drops both flags
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cond_on <= '0;
      reported <= '0;
    end else if (scanning) begin
      cond_on[sc_idx] <= e_cond;
      reported[sc_idx] <= e_active;
    end
  end

  // Time marks and rate reference, kept without reset
  always_ff @(posedge clk_sys) begin
    if (scanning) begin
      if (e_cond && !e_on) cond_since[sc_idx] <= sec_now;
      if (rate_roll || e_type != T_RATE) begin
        rate_since[sc_idx] <= sec_now;
        rate_ref[sc_idx] <= e_val[VAL_W-1:0];
      end
    end
  end

  // Gather relay and alarm summary during the scan
  logic [N_RELAY-1:0] e_relay;
  genvar r;
  generate
    for (r = 0; r < N_RELAY; r++) begin : g_relay
      assign e_relay[r] = e_active && e_contact == 4'(r + 1) && relay_enable[r];
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      relay_acc <= '0;
      alarm_acc <= 1'b0;
      relay_req <= '0;
      any_alarm <= 1'b0;
    end else if (scanning) begin
      relay_acc <= last_entry ? '0 : relay_acc | e_relay;
      alarm_acc <= last_entry ? 1'b0 : alarm_acc | e_active;
      if (last_entry) begin
        relay_req <= relay_acc | e_relay;
        any_alarm <= alarm_acc | e_active;
      end
    end
  end

  // Acknowledge: held until logged, a new press wins over the clear
  wire ack_logged = !e_report && ack_pend;
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack_pend <= 1'b0;
      acked <= 1'b0;
    end else begin
      ack_pend <= ack_press || (ack_pend && !ack_logged);
      if (ack_press) acked <= 1'b1;
      else if (e_report) acked <= 1'b0;
    end
  end

  // Log port and record request; an alarm report takes the slot before an ack
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      log_valid <= 1'b0;
      log_kind <= LOG_ALARM;
      log_time <= '0;
      log_chan <= '0;
      log_slot <= '0;
      log_msg_valid <= 1'b0;
      log_msg <= '0;
      rec_start <= 1'b0;
    end else begin
      log_valid <= e_report || ack_logged;
      rec_start <= e_report && cfg_flags[sc_idx][1] && ctrl[CTRL_RECACC];
      if (e_report) begin
        log_kind <= LOG_ALARM;
        log_time <= time_stamp;
        log_chan <= sc_ch + 5'h1;
        log_slot <= sc_sl + 3'h1;
        log_msg_valid <= cfg_flags[sc_idx][2];
        log_msg <= cfg_flags[sc_idx][2] ? cfg_msg[sc_idx] : '0;
      end else if (ack_logged) begin
        log_kind <= LOG_ACK;
        log_time <= time_stamp;
        log_chan <= '0;
        log_slot <= '0;
        log_msg_valid <= 1'b0;
        log_msg <= '0;
      end
    end
  end

  // Indicator and sound; ack only silences, the colour is untouched
  wire red_n = master_en && !any_alarm;
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      led_green <= 1'b0;
      led_amber <= 1'b0;
      led_red <= 1'b1;
      sound_on <= 1'b0;
    end else begin
      led_red <= !red_n;
      led_amber <= red_n && muted;
      led_green <= red_n && !muted;
      sound_on <= master_en && any_alarm && !muted && !acked;
    end
  end

  // Checks
  a_master_red: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    !master_en |=> led_red) else $error("red not shown with master off");
  a_master_quiet: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    !master_en |-> !e_report) else $error("report with master off");
  a_one_colour: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    $onehot({led_green, led_amber, led_red})) else $error("indicator not one colour");
  a_mute_silent: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    muted |=> !sound_on) else $error("sound while muted");
  a_ack_silent: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    ack_press ##1 !e_report |=> !sound_on) else $error("sound after ack");
  a_ack_logged: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    ack_press |-> ##[1:100] (log_valid && log_kind == LOG_ACK)) else $error("ack not logged");
  a_report_log: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    e_report |=> log_valid && log_kind == LOG_ALARM && log_slot == $past(sc_sl) + 3'h1)
    else $error("report not logged");
  a_hyst_refuse: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    wr_slot && reg_addr == OFF_HYST && $signed(new_val) > $signed(cur_sp) |=> err_flag && cur_hyst == $past(cur_hyst))
    else $error("hysteresis above setpoint accepted");
  a_type_refuse: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    wr_slot && reg_addr == OFF_SLOTCFG && !type_ok |=> err_flag) else $error("illegal type accepted");
  a_rec_gate: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    rec_start |-> $past(e_report && ctrl[CTRL_RECACC])) else $error("record without report");
  a_scan_span: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    scan_state == S_IDLE && sample_tick |=> scanning [*8]) else $error("scan too short");
  c_report: cover property (@(posedge clk_sys) disable iff (!rst_sync_n) e_report);
  c_ack: cover property (@(posedge clk_sys) disable iff (!rst_sync_n) log_valid && log_kind == LOG_ACK);
  c_relay: cover property (@(posedge clk_sys) disable iff (!rst_sync_n) |relay_req);
  c_amber: cover property (@(posedge clk_sys) disable iff (!rst_sync_n) led_amber);
endmodule : channel_alarm_evaluator

// ==== acq_front_model.sv ====
// Model of the acquisition front end and relay logic facing the alarm evaluator
`timescale 1ns/1ns
module acq_front_model
  import alarm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic scan_go,
  input wire logic [15:0] ch1_value,
  output logic sample_tick,
  output logic [alarm_pkg::N_CHAN*alarm_pkg::VAL_W-1:0] chan_value,
  output logic [alarm_pkg::N_CHAN-1:0] chan_abnormal,
  output logic [alarm_pkg::N_CHAN-1:0] chan_contact,
  output logic [alarm_pkg::N_RELAY-1:0] relay_enable
);
  // Tick trails the request by one edge and lasts exactly as long as the request does
  always @(posedge clk_sys) begin
    sample_tick <= scan_go;
  end
  // Only channel 1 is live; its value changes between scans only, never inside one
  assign chan_value = {{(N_CHAN-1)*VAL_W{1'b0}}, ch1_value};
  assign chan_abnormal = '0;
  assign chan_contact = '0;
  assign relay_enable = '1;
endmodule : acq_front_model

// ==== channel_alarm_evaluator_tb.sv ====
// Self-checking bench for the channel alarm evaluator
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module channel_alarm_evaluator_tb;
  import alarm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic scan_go = 1'b0;
  logic [15:0] ch1_value = 16'h0000;
  logic ack_press = 1'b0;
  logic [31:0] time_stamp = 32'h0000_0000;
  logic sample_tick;
  logic [N_CHAN*VAL_W-1:0] chan_value;
  logic [N_CHAN-1:0] chan_abnormal;
  logic [N_CHAN-1:0] chan_contact;
  logic [N_RELAY-1:0] relay_enable;
  logic led_green, led_amber, led_red, sound_on, rec_start, log_valid, log_kind, log_msg_valid;
  logic [N_RELAY-1:0] relay_req;
  logic [31:0] log_time;
  logic [4:0] log_chan;
  logic [2:0] log_slot;
  logic [MSG_W-1:0] log_msg;
  logic [31:0] rv;
  int num_errors = 0;
  int n_tests = 0;
  int n_rep = 0;
  int n_ack = 0;
  int n_rec = 0;
  always #5 clk_sys = ~clk_sys;
  // A short second keeps delay and window counts cheap
  channel_alarm_evaluator #(.SEC_DIV(20)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_tick(sample_tick),
    .chan_value(chan_value), .chan_abnormal(chan_abnormal), .chan_contact(chan_contact),
    .relay_enable(relay_enable), .ack_press(ack_press), .time_stamp(time_stamp), .led_green(led_green),
    .led_amber(led_amber), .led_red(led_red), .sound_on(sound_on), .relay_req(relay_req), .rec_start(rec_start),
    .log_valid(log_valid), .log_kind(log_kind), .log_time(log_time), .log_chan(log_chan), .log_slot(log_slot),
    .log_msg_valid(log_msg_valid), .log_msg(log_msg));
  acq_front_model u_front (.clk_sys(clk_sys), .scan_go(scan_go), .ch1_value(ch1_value),
    .sample_tick(sample_tick), .chan_value(chan_value), .chan_abnormal(chan_abnormal),
    .chan_contact(chan_contact), .relay_enable(relay_enable));
  // Tally log entries and record requests; each pulse stands one cycle only
  always @(posedge clk_sys) begin
    time_stamp <= time_stamp + 32'h0000_0001;
    if (log_valid === 1'b1 && log_kind === LOG_ALARM) n_rep++;
    if (log_valid === 1'b1 && log_kind === LOG_ACK) n_ack++;
    if (log_valid === 1'b1) `CHK("log time", time_stamp - 32'h0000_0001, log_time)
    if (rec_start === 1'b1) n_rec++;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  // n full scans of 90 slots each, with settling margin before each next tick
  task automatic scan(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      scan_go <= 1'b1;
      @(posedge clk_sys);
      scan_go <= 1'b0;
      repeat (100) @(posedge clk_sys);
    end
  endtask : scan
  task automatic complete_run();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  // Watchdog sized well past the full sequence
  initial begin
    #400000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    `CHK("reset red", 1'b1, led_red)
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(OFF_SEL);
    `CHK("sel reset", 32'h0000_0101, rv)
    rd(OFF_CTRL);
    `CHK("ctrl reset", 32'h0000_0000, rv)
    // Slot memories other than setpoint and hysteresis have no reset: clear every slot of every channel first
    for (int c = 1; c <= N_CHAN; c++) begin
      for (int s = 1; s <= N_SLOT; s++) begin
        wr(OFF_SEL, (s << 8) | c);
        wr(OFF_SLOTCFG, 32'h0000_0000);
      end
      wr(OFF_CHCFG, 32'h0000_0000);
    end
    wr(OFF_SEL, 32'h0000_0101);
    wr(OFF_CHCFG, 32'h0000_0001);
    wr(OFF_SETPT, 32'h0000_0064);
    wr(OFF_HYST, 32'h0000_000A);
    wr(OFF_DELAY, 32'h0000_0000);
    wr(OFF_SLOTCFG, 32'h0000_0131);
    wr(OFF_SLOTCFG, 32'h0000_0135);
    rd(OFF_STATUS);
    `CHK("bad type err", 1'b1, rv[STAT_ERR])
    wr(OFF_STATUS, 32'h0000_0002);
    wr(OFF_HYST, 32'h0000_00C8);
    rd(OFF_STATUS);
    `CHK("hyst err", 1'b1, rv[STAT_ERR])
    wr(OFF_STATUS, 32'h0000_0002);
    rd(OFF_SLOTCFG);
    `CHK("slot kept", 32'h0000_0131, rv)
    wr(OFF_CTRL, 32'h0000_0005);
    ch1_value <= 16'h0064;
    scan(3);
    `CHK("equal no alarm", 0, n_rep)
    `CHK("green idle", 1'b1, led_green)
    ch1_value <= 16'h0065;
    scan(3);
    `CHK("one report", 1, n_rep)
    `CHK("log chan", 5'h01, log_chan)
    `CHK("log slot", 3'h1, log_slot)
    `CHK("no msg", 1'b0, log_msg_valid)
    `CHK("record", 1, n_rec)
    `CHK("relay on", 12'h001, relay_req)
    `CHK("red alarm", 1'b1, led_red)
    `CHK("sound", 1'b1, sound_on)
    @(posedge clk_sys);
    ack_press <= 1'b1;
    @(posedge clk_sys);
    ack_press <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK("ack quiet", 1'b0, sound_on)
    `CHK("ack red", 1'b1, led_red)
    `CHK("ack log", 1, n_ack)
    `CHK("ack chan", 5'h00, log_chan)
    ch1_value <= 16'h005F;
    scan(1);
    `CHK("held in band", 12'h001, relay_req)
    ch1_value <= 16'h0059;
    scan(1);
    `CHK("released", 12'h000, relay_req)
    ch1_value <= 16'h0064;
    scan(2);
    `CHK("setpoint restored", 1, n_rep)
    wr(OFF_CTRL, 32'h0000_0000);
    ch1_value <= 16'h0065;
    scan(3);
    `CHK("master off", 1, n_rep)
    `CHK("master red", 1'b1, led_red)
    wr(OFF_CTRL, 32'h0000_0003);
    ch1_value <= 16'h0032;
    scan(2);
    `CHK("amber", 1'b1, led_amber)
    // Append the message and keep record on; triggers are no longer accepted
    wr(OFF_MSG0, 32'h4443_4241);
    wr(OFF_SLOTCFG, 32'h0000_0171);
    ch1_value <= 16'h0065;
    scan(3);
    `CHK("muted report", 2, n_rep)
    `CHK("muted silent", 1'b0, sound_on)
    `CHK("muted red", 1'b1, led_red)
    `CHK("msg flag", 1'b1, log_msg_valid)
    `CHK("msg word0", 32'h4443_4241, log_msg[31:0])
    `CHK("record gated", 1, n_rec)
    rd(OFF_STATUS);
    `CHK("muted status", 32'h0000_0001, rv)
    complete_run();
  end
endmodule : channel_alarm_evaluator_tb
